// ==== core/pcs_regs.svh ====
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_PC_W        10
`define PCS_PAGE_WORDS  1024
`define PCS_STACK_DEPTH 5
`define PCS_DATA_W      8
`define PCS_ADDR_W      8

`define PCS_PC_OFS      8'h02
`define PCS_STAT_OFS    8'h10

`define PCS_PC_RST      10'h000

`define PCS_UPPER_MSB   9
`define PCS_UPPER_LSB   8

`define PCS_STAT_DEPTH_LSB 0
`define PCS_STAT_DEPTH_MSB 2
`define PCS_STAT_LONG_BIT  3
`define PCS_STAT_FLUSH_BIT 4

`define PCS_CYC_SHORT   2
`define PCS_CYC_LONG    4
`endif

// ==== core/pcs_pkg.sv ====
package pcs_pkg;

  typedef logic [9:0] pcs_addr_t;

  typedef enum logic [2:0] {
    PCS_OP_STEP = 3'h0,
    PCS_OP_JUMP = 3'h1,
    PCS_OP_CALL = 3'h2,
    PCS_OP_RET  = 3'h3,
    PCS_OP_RETL = 3'h4,
    PCS_OP_RETURN_INTERRUPT_INSTR = 3'h5
  } pcs_op_e;

  typedef enum logic [1:0] {
    PCS_ST_EXEC  = 2'b01,
    PCS_ST_FLUSH = 2'b10
  } pcs_state_e;

endpackage : pcs_pkg

// ==== core/pcs_program_counter.sv ====
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_program_counter #(
  parameter int PC_W        = `PCS_PC_W,
  parameter int STACK_DEPTH = `PCS_STACK_DEPTH
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_long_cycle_opt,
  input  wire pcs_pkg::pcs_op_e        i_op,
  input  wire pcs_pkg::pcs_addr_t      i_target,
  input  wire logic [`PCS_ADDR_W-1:0]  i_addr,
  input  wire logic [`PCS_DATA_W-1:0]  i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [`PCS_DATA_W-1:0]  o_rdata,
  output logic                         o_accept,
  output pcs_pkg::pcs_addr_t           o_pc,
  output logic      [2:0]              o_stack_depth,
  output logic                         o_return_interrupt_instr_done
);
  import pcs_pkg::*;

  localparam logic [1:0] PH_SHORT_LAST = 2'(`PCS_CYC_SHORT - 1);
  localparam logic [1:0] PH_LONG_LAST  = 2'(`PCS_CYC_LONG - 1);
  localparam logic [2:0] STK_LAST      = 3'(STACK_DEPTH - 1);
  localparam logic [2:0] STK_FULL      = 3'(STACK_DEPTH);

  // counter state
  pcs_addr_t  pc;
  pcs_addr_t  pc_inc;
  pcs_addr_t  next_pc;

  // return stack
  pcs_addr_t  stack_mem [STACK_DEPTH];
  logic [2:0] stack_wp;
  logic [2:0] stack_wp_dec;
  logic [2:0] stack_wp_inc;
  logic [2:0] depth;

  // instruction cycle timing
  logic       long_cycle;
  logic       opt_armed;
  logic [1:0] phase;
  logic [1:0] phase_last;
  logic       cycle_start;

  pcs_state_e state;
  pcs_state_e next_state;

  // decoded events
  logic       pc_reg_wr;
  logic       take_op;
  logic       do_push;
  logic       do_pop;
  logic       changes_pc;
  logic       is_return;

  // ------------------------------------------------------------------
  // code option: sampled once, one edge after reset release, so that
  // the flop never takes a port value under the asynchronous reset
  // ------------------------------------------------------------------
  // the option is meant to be a strap: it is not watched afterwards,
  // so a change of the pin while running has no effect until the
  // next reset; this keeps the cycle length stable inside a program
  // and avoids a half-length instruction cycle at a mode change
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_armed  <= 1'b1;
      long_cycle <= 1'b0;
    end else if (opt_armed) begin
      opt_armed  <= 1'b0;
      long_cycle <= i_long_cycle_opt;
    end
  end

  // ------------------------------------------------------------------
  // phase counter: one wrap is one instruction cycle
  // ------------------------------------------------------------------
  // phase 0 is the only edge on which an instruction is taken; the
  // other phases of the cycle only let the counter settle
  // the compare is >= rather than == so that a phase left high by any
  // upset still folds back to zero within one clock
  always_comb begin
    if (long_cycle) begin
      phase_last = PH_LONG_LAST;
    end else begin
      phase_last = PH_SHORT_LAST;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase <= 2'h0;
    end else if (opt_armed || phase >= phase_last) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // held off during the strap capture so the cycle length is settled
  assign cycle_start = (phase == 2'h0) && !opt_armed;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  // the counter register is decoded on the full address so that no
  // alias of it exists elsewhere in the map
  // the status register is read only; writes to it fall through the
  // decode and are lost without any side effect
  assign pc_reg_wr = i_wr && (i_addr == `PCS_PC_OFS);

  // a bus write to the counter wins over an instruction offered in
  // the same edge; the instruction is dropped, not deferred
  assign o_accept = cycle_start && (state == PCS_ST_EXEC) && !pc_reg_wr;
  assign take_op  = o_accept;

  always_comb begin
    is_return = 1'b0;
    case (i_op)
      PCS_OP_RET:  is_return = 1'b1;
      PCS_OP_RETL: is_return = 1'b1;
      PCS_OP_RETURN_INTERRUPT_INSTR: is_return = 1'b1;
      default:     is_return = 1'b0;
    endcase
  end

  assign do_push    = take_op && (i_op == PCS_OP_CALL);
  assign do_pop     = take_op && is_return;
  assign changes_pc = pc_reg_wr || (take_op && (i_op != PCS_OP_STEP));

  // ------------------------------------------------------------------
  // stack pointer arithmetic, wrapping over the five slots
  // ------------------------------------------------------------------
  // the pointer wraps modulo the depth instead of a power of two, so
  // the three pointer bits never name a slot that does not exist
  // a pop from an empty stack still moves the pointer back; the
  // returned address is then whatever the slot last held
  always_comb begin
    if (stack_wp == 3'h0) begin
      stack_wp_dec = STK_LAST;
    end else begin
      stack_wp_dec = stack_wp - 3'h1;
    end
    if (stack_wp == STK_LAST) begin
      stack_wp_inc = 3'h0;
    end else begin
      stack_wp_inc = stack_wp + 3'h1;
    end
  end

  // 10-bit adder wraps at the page end, so every one of the 1024
  // words is reachable and the counter never leaves the page
  assign pc_inc = pc + 10'h001;

  // ------------------------------------------------------------------
  // next counter value
  // ------------------------------------------------------------------
  // a data write takes only the low byte and forces the two upper
  // counter bits to zero, so computed jumps stay in the first quarter
  // of the page; a jump or call reaches the whole page
  // a return reads the slot just below the write pointer, which is
  // the newest entry whatever the overflow history
  always_comb begin
    next_pc = pc;
    if (pc_reg_wr) begin
      next_pc = {2'b00, i_wdata};
    end else if (take_op) begin
      case (i_op)
        PCS_OP_STEP: next_pc = pc_inc;
        PCS_OP_JUMP: next_pc = i_target;
        PCS_OP_CALL: next_pc = i_target;
        PCS_OP_RET:  next_pc = stack_mem[stack_wp_dec];
        PCS_OP_RETL: next_pc = stack_mem[stack_wp_dec];
        PCS_OP_RETURN_INTERRUPT_INSTR: next_pc = stack_mem[stack_wp_dec];
        default:     next_pc = pc_inc;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc <= `PCS_PC_RST;
    end else begin
      pc <= next_pc;
    end
  end

  assign o_pc = pc;

  // ------------------------------------------------------------------
  // return stack storage: the write pointer always names the slot the
  // next push lands in, so a sixth push reuses the oldest slot
  // ------------------------------------------------------------------
  generate
    for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
          stack_mem[g] <= `PCS_PC_RST;
        end else if (do_push && (stack_wp == 3'(g))) begin
          stack_mem[g] <= pc_inc;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stack_wp <= 3'h0;
    end else if (do_push) begin
      stack_wp <= stack_wp_inc;
    end else if (do_pop) begin
      stack_wp <= stack_wp_dec;
    end
  end

  // depth saturates at five; overflow raises nothing
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      depth <= 3'h0;
    end else if (do_push && depth != STK_FULL) begin
      depth <= depth + 3'h1;
    end else if (do_pop && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end

  assign o_stack_depth = depth;

  // ------------------------------------------------------------------
  // extra instruction cycle after any change of the counter
  // ------------------------------------------------------------------
  // the flush state stands for the fetch that would otherwise use a
  // stale address: the cycle after a change is spent idle, and the
  // next phase 0 after it is the first new take
  // a plain step never enters the flush state
  always_comb begin
    next_state = state;
    case (state)
      PCS_ST_EXEC: begin
        if (changes_pc) begin
          next_state = PCS_ST_FLUSH;
        end
      end
      PCS_ST_FLUSH: begin
        // the flushed cycle starts here; a new write restarts it
        if (pc_reg_wr) begin
          next_state = PCS_ST_FLUSH;
        end else if (cycle_start) begin
          next_state = PCS_ST_EXEC;
        end
      end
      default: next_state = PCS_ST_EXEC;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= PCS_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // the global interrupt enable lives outside; it only needs the event
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_return_interrupt_instr_done <= 1'b0;
    end else begin
      o_return_interrupt_instr_done <= take_op && (i_op == PCS_OP_RETURN_INTERRUPT_INSTR);
    end
  end

  // ------------------------------------------------------------------
  // register read port: data stands in the cycle after the strobe
  // ------------------------------------------------------------------
  // the data return to zero outside a read so that an or-combined
  // read bus outside this block needs no extra gating
  // reads have no side effect; the status fields are snapshots taken
  // at the strobe edge
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == `PCS_PC_OFS) begin
        // only the low byte fits the data path; bits 8 and 9 are in
        // no readable register and show only on the output o_pc
        o_rdata <= pc[`PCS_DATA_W-1:0];
      end else if (i_addr == `PCS_STAT_OFS) begin
        o_rdata <= '0;
        o_rdata[`PCS_STAT_DEPTH_MSB:`PCS_STAT_DEPTH_LSB] <= depth;
        o_rdata[`PCS_STAT_LONG_BIT]  <= long_cycle;
        o_rdata[`PCS_STAT_FLUSH_BIT] <= (state == PCS_ST_FLUSH);
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : pcs_program_counter

// ==== testbench/pcs_program_counter_sva.sv ====
`timescale 1ns/1ps
module pcs_program_counter_sva (
  input wire logic               i_clk_sys,
  input wire logic               i_rst_b,
  input wire logic               i_long_cycle_opt,
  input wire pcs_pkg::pcs_op_e   i_op,
  input wire pcs_pkg::pcs_addr_t i_target,
  input wire logic [7:0]         i_addr,
  input wire logic [7:0]         i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [7:0]         o_rdata,
  input wire logic               o_accept,
  input wire pcs_pkg::pcs_addr_t o_pc,
  input wire logic [2:0]         o_stack_depth,
  input wire logic               o_return_interrupt_instr_done
);
  import pcs_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic pc_wr;
  logic pop;
  assign pc_wr = i_wr && i_addr == 8'h02;
  assign pop = o_accept && i_op inside {PCS_OP_RET, PCS_OP_RETL, PCS_OP_RETURN_INTERRUPT_INSTR};
  // a change costs one whole instruction cycle with no take
  sequence s_gap2; !o_accept[*3] ##1 o_accept; endsequence
  sequence s_gap4; !o_accept[*7] ##1 o_accept; endsequence
  a_jump_load: assert property (o_accept && i_op == PCS_OP_JUMP |=> o_pc == $past(i_target))
    else $error("jump target not loaded");
  a_step_incr: assert property (o_accept && i_op == PCS_OP_STEP |=> o_pc == $past(o_pc) + 10'h001)
    else $error("step did not add one");
  a_call_push: assert property (o_accept && i_op == PCS_OP_CALL |=> o_pc == $past(i_target) &&
    o_stack_depth == (($past(o_stack_depth) == 3'h5) ? 3'h5 : $past(o_stack_depth) + 3'h1))
    else $error("call load or push wrong");
  a_pop_depth: assert property (pop && o_stack_depth != 3'h0 |=> o_stack_depth == $past(o_stack_depth) - 3'h1)
    else $error("return did not pop");
  a_write_clear: assert property (pc_wr |=> o_pc == {2'b00, $past(i_wdata)})
    else $error("counter write kept upper bits");
  a_write_wins: assert property (pc_wr |-> !o_accept)
    else $error("take beside counter write");
  a_change_gap: assert property (o_accept && i_op != PCS_OP_STEP |=>
    if (i_long_cycle_opt) s_gap4 else s_gap2)
    else $error("extra cycle missing");
  a_step_gap: assert property (o_accept && i_op == PCS_OP_STEP && !i_long_cycle_opt |=>
    !o_accept ##1 (o_accept || pc_wr || $past(pc_wr)))
    else $error("step cycle length wrong");
  a_return_interrupt_instr_pulse: assert property (o_accept && i_op == PCS_OP_RETURN_INTERRUPT_INSTR |=> o_return_interrupt_instr_done ##1 !o_return_interrupt_instr_done)
    else $error("interrupt return pulse wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
endmodule : pcs_program_counter_sva
bind pcs_program_counter pcs_program_counter_sva i_pcs_program_counter_sva (.*);

// ==== testbench/program_counter_stack_tb.sv ====
`timescale 1ns/1ps
module program_counter_stack_tb;
  import pcs_pkg::*;
  logic i_clk_sys, i_rst_b, i_long_cycle_opt, i_wr, i_rd, o_accept, o_return_interrupt_instr_done;
  pcs_op_e i_op;
  pcs_addr_t i_target, o_pc, exp_pc;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [2:0] o_stack_depth;
  pcs_addr_t stk[$];
  int num_errors = 0;
  int checks_done = 0;
  bit rnd_on;
  pcs_program_counter i_pcs_program_counter (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_long_cycle_opt(i_long_cycle_opt), .i_op(i_op), .i_target(i_target), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_accept(o_accept),
    .o_pc(o_pc), .o_stack_depth(o_stack_depth), .o_return_interrupt_instr_done(o_return_interrupt_instr_done));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(string nm, logic [9:0] seen, logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // model checks the state left by the last edge, then predicts the next one
  always @(negedge i_clk_sys) begin
    if (!i_rst_b) begin
      check("pc in reset", o_pc, 10'h000);
      exp_pc = 10'h000;
      stk = {};
    end else begin
      check("pc", o_pc, exp_pc);
      check("depth", 10'(o_stack_depth), 10'(stk.size()));
      if (i_wr && i_addr == 8'h02) begin
        exp_pc = {2'b00, i_wdata};
      end else if (o_accept) begin
        case (i_op)
          PCS_OP_STEP: exp_pc = exp_pc + 10'h001;
          PCS_OP_JUMP: exp_pc = i_target;
          PCS_OP_CALL: begin
            stk.push_back(exp_pc + 10'h001);
            if (stk.size() > 5) void'(stk.pop_front());
            exp_pc = i_target;
          end
          default: exp_pc = stk.pop_back();
        endcase
      end
    end
  end
  // returns only while the stack holds something: an empty pop is stale
  always @(posedge i_clk_sys) begin
    if (rnd_on) begin
      i_op <= pcs_op_e'(3'((stk.size() == 0) ? $urandom % 3 : $urandom % 6));
      i_target <= 10'($urandom);
    end
  end
  task automatic hold(pcs_op_e op, int n, pcs_addr_t t);
    @(posedge i_clk_sys);
    i_op <= op;
    i_target <= t;
    repeat (n) begin
      do @(negedge i_clk_sys); while (!o_accept);
    end
    @(posedge i_clk_sys);
    i_op <= PCS_OP_STEP;
  endtask : hold
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m, string nm);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    #1;
    if (a == 8'h02) e = exp_pc[7:0];
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check(nm, 10'(o_rdata & m), 10'(e));
  endtask : rd
  initial begin
    #60000;
    num_errors++;
    complete_run();
  end
  initial begin
    i_rst_b = 1'b0;
    i_long_cycle_opt = 1'b0;
    i_op = PCS_OP_STEP;
    i_target = 10'h000;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    rnd_on = 1'b0;
    void'($urandom(32'h5b1b29e3));
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk_sys);
      i_rst_b <= 1'b0;
      i_long_cycle_opt <= m[0];
      repeat (6) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      rnd_on <= 1'b1;
      repeat (500) @(posedge i_clk_sys);
      rnd_on <= 1'b0;
      hold(PCS_OP_CALL, 6, 10'($urandom));
      hold(PCS_OP_RETURN_INTERRUPT_INSTR, 2, 10'h000);
      hold(PCS_OP_RETL, 2, 10'h000);
      hold(PCS_OP_RET, 1, 10'h000);
      hold(PCS_OP_JUMP, 1, 10'h3ff);
      hold(PCS_OP_STEP, 1, 10'h000);
      repeat (10) @(posedge i_clk_sys);
      repeat (6) begin
        wr(8'h02, 8'($urandom));
        rd(8'h02, 8'h00, 8'hff, "pc low byte");
      end
      rd(8'h10, {4'h0, m[0], 3'h0}, 8'h0f, "status");
      wr(8'h10, 8'hff);
      rd(8'h10, {4'h0, m[0], 3'h0}, 8'h0f, "status kept");
      rd(8'h33, 8'h00, 8'hff, "unmapped");
      $display("test done: cycle mode %0d", m);
    end
    complete_run();
  end
endmodule : program_counter_stack_tb
